// ==== rtl/stic_cfg.svh ====
// Constants of the serial time interval counter.
`ifndef STIC_CFG_SVH
`define STIC_CFG_SVH
`define STIC_CNT_W 24
`define STIC_ADDR_W 11
`define STIC_DEPTH_1K 1024
`define STIC_DEPTH_2K 2048
`define STIC_CNT_TERM 24'hffffff
`define STIC_LAST_1K 11'h3ff
`define STIC_LAST_2K 11'h7ff
`define STIC_DIV10 10'h009
`define STIC_DIV100 10'h063
`define STIC_DIV1000 10'h3e7
`define STIC_STOP_MAX_HZ 1000000
`define STIC_CLK_HZ 250000000
`define STIC_STOP_GAP_CYC (`STIC_CLK_HZ / `STIC_STOP_MAX_HZ)
`endif

// ==== rtl/stic_pkg.sv ====
// Types shared by the serial time interval counter.
package stic_pkg;
  typedef enum logic [1:0] {
    STIC_DIV_1 = 2'h0,
    STIC_DIV_10 = 2'h1,
    STIC_DIV_100 = 2'h2,
    STIC_DIV_1000 = 2'h3
  } stic_div_t;
  typedef struct packed {
    logic ext_clk_sel;
    stic_div_t div_sel;
    logic depth_1k;
  } stic_sw_t;
  typedef struct packed {
    logic armed;
    logic counting;
    logic mem_full;
    logic overflowed;
    logic late_stop;
  } stic_stat_t;
  typedef enum logic [2:0] {
    STIC_IDLE = 3'b001,
    STIC_ARMED = 3'b010,
    STIC_COUNT = 3'b100
  } stic_state_t;
endpackage

// ==== rtl/stic_mem.sv ====
// Interval store: one write port, registered read port.
`timescale 1ns/100ps
`default_nettype none
module stic_mem #(
  parameter int AW = 11,
  parameter int DW = 24
) (
  input wire logic clk_i, // Clock.
  input wire logic we_i, // Write strobe.
  input wire logic [AW-1:0] waddr_i, // Write address.
  input wire logic [DW-1:0] wdata_i, // Write data.
  input wire logic [AW-1:0] raddr_i, // Read address.
  output logic [DW-1:0] rdata_o // Registered read data.
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end
endmodule
`default_nettype wire

// ==== rtl/stic_core.sv ====
// Serial time interval counter core.
`timescale 1ns/100ps
`default_nettype none
`include "stic_cfg.svh"
// What this block does
// [RULE1] Arm clears counter and write address.
// [RULE2] First start after arm begins counting.
// [RULE3] Later starts ignored until next arm.
// [RULE4] Each stop stores count, advances address.
// [RULE5] Switch selects depth 1024 or 2048.
// [RULE6] Full memory or terminal count ends count.
// [RULE7] Arm while counting stops and rearms.
// [RULE8] Disarm command or pulse ends everything.
// [RULE9] Switch selects bus or external clock.
// [RULE10] Prescaler divides by 1, 10, 100, 1000.
// [RULE11] Stops accepted up to one megahertz.
// [RULE12] First stop at zero, last at top.
// [RULE13] Stop after overflow sets flag; arm clears.
// [RULE14] Async inputs synchronised and edge detected.
// [RULE15] Armed and counting state tracking.
module stic_core
  import stic_pkg::*;
#(
  parameter int CNT_W = `STIC_CNT_W,
  parameter int ADDR_W = `STIC_ADDR_W
) (
  input wire logic clk_i, // Logic clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic arm_i, // Arm command pulse from the decoder.
  input wire logic disarm_i, // Disarm command pulse from the decoder.
  input wire stic_pkg::stic_sw_t sw_i, // Switch settings.
  input wire logic bus_clk_i, // Bus clock pin, asynchronous.
  input wire logic ext_clk_i, // External clock pin, asynchronous.
  input wire logic start_i, // Start pin, asynchronous.
  input wire logic stop_i, // Stop pin, asynchronous.
  input wire logic ext_disarm_i, // External disarm pin, asynchronous.
  input wire logic [ADDR_W-1:0] rd_addr_i, // Memory read address.
  output logic [CNT_W-1:0] rd_data_o, // Memory read data.
  output stic_pkg::stic_stat_t stat_o, // Status flags.
  output logic [ADDR_W:0] nstops_o, // Valid stops this count.
  output logic [ADDR_W-1:0] waddr_o, // Current write address.
  output logic [CNT_W-1:0] count_o // Live interval count.
);
  import stic_pkg::*;
  initial begin
    if (CNT_W != 24 || ADDR_W != 11) begin
      $error("stic_core supports only 24-bit counts and 11-bit addresses.");
    end
  end
  // ==========================================================
  // Input synchronisers and edge detectors.
  logic [4:0] s1_r, s2_r, s3_r;
  logic [4:0] pins, rise;
  assign pins = {ext_disarm_i, stop_i, start_i, ext_clk_i, bus_clk_i};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
    end else begin
      s1_r <= pins; // RULE14
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise = s2_r & ~s3_r; // RULE14
  logic clk_ev, start_ev, stop_ev, xdis_ev;
  assign clk_ev = sw_i.ext_clk_sel ? rise[1] : rise[0]; // RULE9
  assign start_ev = rise[2];
  assign stop_ev = rise[3];
  assign xdis_ev = rise[4];
  // ==========================================================
  // Prescaler.
  logic [9:0] pre_r, pre_nxt, pre_top;
  logic tick;
  always_comb begin
    case (sw_i.div_sel)
      STIC_DIV_10: pre_top = `STIC_DIV10;
      STIC_DIV_100: pre_top = `STIC_DIV100;
      STIC_DIV_1000: pre_top = `STIC_DIV1000;
      default: pre_top = 10'h000;
    endcase
  end
  stic_state_t st_r, st_nxt;
  assign tick = clk_ev && (pre_r >= pre_top); // RULE10
  always_comb begin
    pre_nxt = pre_r;
    if (st_r != STIC_COUNT) begin
      pre_nxt = 10'h000;
    end else if (clk_ev) begin
      pre_nxt = tick ? 10'h000 : pre_r + 10'h001; // RULE10
    end
  end
  // ==========================================================
  // Control state, counter and address.
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] wa_r, wa_nxt, last_a;
  logic [ADDR_W:0] ns_r, ns_nxt;
  logic full_r, full_nxt, ovf_r, ovf_nxt, late_r, late_nxt;
  logic we;
  assign last_a = sw_i.depth_1k ? `STIC_LAST_1K : `STIC_LAST_2K; // RULE5
  assign we = (st_r == STIC_COUNT) && stop_ev; // RULE4 RULE11
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wa_nxt = wa_r;
    ns_nxt = ns_r;
    full_nxt = full_r;
    ovf_nxt = ovf_r;
    late_nxt = late_r;
    if (stop_ev && ovf_r) begin
      late_nxt = 1'b1; // RULE13
    end
    if (arm_i) begin
      st_nxt = STIC_ARMED; // RULE1 RULE7 RULE15
      cnt_nxt = '0;
      wa_nxt = '0;
      ns_nxt = '0;
      full_nxt = 1'b0;
      ovf_nxt = 1'b0;
      // A late stop in the same cycle as the arm still wins the flag.
      late_nxt = stop_ev && ovf_r; // RULE13
    end else if (disarm_i || xdis_ev) begin
      st_nxt = STIC_IDLE; // RULE8 RULE15
      cnt_nxt = '0;
      wa_nxt = '0;
    end else begin
      case (st_r)
        STIC_ARMED: begin
          if (start_ev) begin
            st_nxt = STIC_COUNT; // RULE2
          end
        end
        STIC_COUNT: begin
          // Further starts fall through unused here.
          if (we) begin
            wa_nxt = wa_r + 1'b1; // RULE4 RULE12
            ns_nxt = ns_r + 1'b1;
          end
          if (tick) begin
            cnt_nxt = cnt_r + 1'b1;
          end
          if (we && wa_r == last_a) begin
            st_nxt = STIC_IDLE; // RULE6
            full_nxt = 1'b1;
            cnt_nxt = '0;
            wa_nxt = '0;
          end else if (tick && cnt_r == `STIC_CNT_TERM - 1'b1) begin
            st_nxt = STIC_IDLE; // RULE6
            ovf_nxt = 1'b1;
            cnt_nxt = '0;
            wa_nxt = '0;
          end
        end
        default: st_nxt = st_r; // RULE3
      endcase
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= STIC_IDLE;
      pre_r <= 10'h000;
      cnt_r <= '0;
      wa_r <= '0;
      ns_r <= '0;
      full_r <= 1'b0;
      ovf_r <= 1'b0;
      late_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      wa_r <= wa_nxt;
      ns_r <= ns_nxt;
      full_r <= full_nxt;
      ovf_r <= ovf_nxt;
      late_r <= late_nxt;
    end
  end
  stic_mem #(.AW(ADDR_W), .DW(CNT_W)) u_mem (
    .clk_i(clk_i),
    .we_i(we),
    .waddr_i(wa_r),
    .wdata_i(cnt_r),
    .raddr_i(rd_addr_i),
    .rdata_o(rd_data_o)
  );
  // ==========================================================
  // Registered outputs.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_o <= '0;
      nstops_o <= '0;
      waddr_o <= '0;
      count_o <= '0;
    end else begin
      stat_o <= '{armed: st_nxt != STIC_IDLE,
                  counting: st_nxt == STIC_COUNT,
                  mem_full: full_nxt,
                  overflowed: ovf_nxt,
                  late_stop: late_nxt};
      nstops_o <= ns_nxt;
      waddr_o <= wa_nxt;
      count_o <= cnt_nxt;
    end
  end
  // ==========================================================
  // Checks.
  sequence arm_seq;
    arm_i;
  endsequence
  arm_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    arm_seq |=> cnt_r == '0 && wa_r == '0 && st_r == STIC_ARMED)
    else $error("Arm did not clear counter and address.");
  start_go_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    st_r == STIC_ARMED && start_ev && !arm_i && !disarm_i && !xdis_ev
    |=> st_r == STIC_COUNT)
    else $error("Start did not begin counting.");
  start_ign_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    st_r == STIC_COUNT && start_ev && !arm_i
    |=> st_r != STIC_ARMED && ($stable(ns_r) || $past(we)))
    else $error("Start changed stop count.");
  // An overflow in the cycle of the stop zeroes the address instead.
  stop_wr_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    we && !arm_i && !disarm_i && !xdis_ev && wa_r != last_a
    |=> wa_r == $past(wa_r) + 1'b1 || (ovf_r && wa_r == '0))
    else $error("Address did not advance after stop.");
  full_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    we && wa_r == last_a && !arm_i && !disarm_i && !xdis_ev
    |=> st_r == STIC_IDLE && wa_r == '0 && full_r)
    else $error("Full memory did not end the count.");
  dis_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    (disarm_i || xdis_ev) && !arm_i
    |=> st_r == STIC_IDLE ##1 st_r != STIC_COUNT)
    else $error("Disarm did not stop the block.");
  div_cap_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    pre_r <= `STIC_DIV1000)
    else $error("Prescaler out of range.");
  late_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    ovf_r && stop_ev |=> late_r)
    else $error("Stop after overflow not flagged.");
endmodule
`default_nettype wire

// ==== verif/stic_src.sv ====
// Front-panel and bus pin source for the counter core.
`timescale 1ns/100ps
`default_nettype none
module stic_src (
  input wire logic clk_i, // Logic clock.
  output logic [4:0] pins_o // Bus clk, ext clk, start, stop, disarm.
);
  initial begin
    pins_o = 5'h00;
  end
  // Each pulse stays high two cycles and low three before the next; the clocks stand still between.
  task automatic pulse(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i) pins_o[idx] = 1'b1;
      repeat (2) @(negedge clk_i);
      pins_o[idx] = 1'b0;
      repeat (2) @(negedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/stic_core_test.sv ====
// Self-checking bench of the serial time interval counter core.
`timescale 1ns/100ps
`default_nettype none
module stic_core_test;
  import stic_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic arm_i = 1'b0;
  logic disarm_i = 1'b0;
  stic_sw_t sw_i = '{1'b1, STIC_DIV_1, 1'b1};
  logic [4:0] pins;
  logic [10:0] rd_addr_i = 11'h000;
  logic [23:0] rd_data_o;
  logic [23:0] count_o;
  stic_stat_t stat_o;
  logic [11:0] nstops_o;
  logic [10:0] waddr_o;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int divs [3] = '{10, 100, 1000};
  stic_div_t dsel [3] = '{STIC_DIV_10, STIC_DIV_100, STIC_DIV_1000};
  stic_core stic_core_inst (
    .clk_i(clk_i), .rst_i(rst_i), .arm_i(arm_i), .disarm_i(disarm_i),
    .sw_i(sw_i), .bus_clk_i(pins[0]), .ext_clk_i(pins[1]),
    .start_i(pins[2]), .stop_i(pins[3]), .ext_disarm_i(pins[4]),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .stat_o(stat_o),
    .nstops_o(nstops_o), .waddr_o(waddr_o), .count_o(count_o)
  );
  stic_src stic_src_inst (.clk_i(clk_i), .pins_o(pins));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic dis);
    @(negedge clk_i);
    if (dis) disarm_i = 1'b1;
    else arm_i = 1'b1;
    @(negedge clk_i);
    arm_i = 1'b0;
    disarm_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic pin(input int idx, input int n);
    stic_src_inst.pulse(idx, n);
    repeat (8) @(negedge clk_i);
  endtask
  // Stops are kept at least one microsecond apart.
  task automatic stop_pulse();
    pin(3, 1);
    repeat (250) @(negedge clk_i);
  endtask
  task automatic rdchk(input logic [10:0] a, input logic [23:0] exp);
    @(negedge clk_i) rd_addr_i = a;
    repeat (2) @(negedge clk_i);
    chk(rd_data_o, exp);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    chk({19'h0, stat_o}, 24'h000000);
    cmd(1'b0);
    chk({19'h0, stat_o}, 24'h000010);
    pin(2, 1);
    chk({19'h0, stat_o}, 24'h000018);
    pin(1, 3);
    chk(count_o, 24'h000003);
    stop_pulse();
    chk({13'h0, waddr_o}, 24'h000001);
    chk({12'h0, nstops_o}, 24'h000001);
    pin(2, 1);
    pin(1, 5);
    pin(0, 4);
    chk(count_o, 24'h000008);
    stop_pulse();
    chk({13'h0, waddr_o}, 24'h000002);
    rdchk(11'h000, 24'h000003);
    rdchk(11'h001, 24'h000008);
    cmd(1'b0);
    chk(count_o, 24'h000000);
    chk({13'h0, waddr_o}, 24'h000000);
    chk({19'h0, stat_o}, 24'h000010);
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_i) sw_i = '{1'b0, dsel[i], 1'b0};
      cmd(1'b0);
      pin(2, 1);
      pin(0, divs[i] - 1);
      chk(count_o, 24'h000000);
      pin(0, 1);
      chk(count_o, 24'h000001);
    end
    stop_pulse();
    cmd(1'b1);
    chk({19'h0, stat_o}, 24'h000000);
    chk({13'h0, waddr_o}, 24'h000000);
    chk(count_o, 24'h000000);
    pin(2, 1);
    chk({19'h0, stat_o}, 24'h000000);
    cmd(1'b0);
    pin(2, 1);
    stop_pulse();
    pin(4, 1);
    chk({19'h0, stat_o}, 24'h000000);
    chk({13'h0, waddr_o}, 24'h000000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
